// ==== include/cfg_agent_params.svh ====
// Contract
// - Every request carries a 24-bit return channel-end identifier, and every reply is addressed to it.
// - A write whose return identifier has its low 8 bits all ones is performed with no reply at all.
// - Fields wider than one byte travel most significant byte first, least significant byte last.
// - A write is answered by tokens 3 and 1 on success, or tokens 4 and 1 on failure.
// - A read is answered by token 3, the 32-bit value and token 1, or on failure by tokens 4 and 1.
// - A status resource identifier is the register number shifted left by 8, ORed with type 0x0B.
// - Processor status reads and writes move one whole 32-bit word.
// - Debug-only registers take effect only in debug mode; otherwise accesses do nothing.
`ifndef CFG_AGENT_PARAMS_SVH
`define CFG_AGENT_PARAMS_SVH

`define TOK_WRITE 8'hC0
`define TOK_READ 8'hC1
`define TOK_END 8'h01
`define TOK_ACK 8'h03
`define TOK_NAK 8'h04
`define NOREPLY_ID 8'hFF
`define PS_RES_TYPE 8'h0B
`define HDR_LAST 4'h4
`define DATA_LAST 4'h3
`define RSP_LEN_READ 3'h6
`define RSP_LEN_SHORT 3'h2

`endif

// ==== include/cfg_agent_pkg.sv ====
package cfg_agent_pkg;

    // One token of the message interconnect: control flag and byte.
    typedef struct packed {
        logic ctrl;
        logic [7:0] val;
    } tok_t;

    // Gray coded along idle, header, data, tail, execute, reply.
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_HDR = 3'b001,
        S_DATA = 3'b011,
        S_TAIL = 3'b010,
        S_EXEC = 3'b110,
        S_REPLY = 3'b111
    } state_t;

endpackage

// ==== rtl/config_register_message_agent.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cfg_agent_params.svh"

module config_register_message_agent import cfg_agent_pkg::*; #(
    parameter int NUM_REGS = 16,
    parameter logic [NUM_REGS-1:0] RO_MASK = 16'h0001,
    parameter logic [NUM_REGS-1:0] DBG_MASK = 16'hFF00
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Request tokens from the interconnect
    input wire tok_t in_tok,
    input wire logic in_valid,
    output logic in_ready,
    // Reply tokens towards the return channel-end
    output tok_t out_tok,
    output logic out_valid,
    output logic [23:0] out_dest,
    input wire logic out_ready,
    // Processor status access
    input wire logic dbg_mode,
    input wire logic proc_req,
    input wire logic proc_wr,
    input wire logic [31:0] proc_resid,
    input wire logic [31:0] proc_wdata,
    output logic proc_ack,
    output logic proc_ok,
    output logic [31:0] proc_rdata
);

    localparam int IW = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;

    if (NUM_REGS < 1 || NUM_REGS > 65536) begin : g_check
        $error("NUM_REGS must lie between 1 and 65536");
    end

    // ==========================================================
    // Helpers
    function automatic logic allowed(input logic [15:0] n, input logic wr, input logic dbg);
        logic in_range;
        in_range = 32'(n) < NUM_REGS;
        if (!in_range) begin
            return 1'b0;
        end
        return !(wr && RO_MASK[n[IW-1:0]]) && (!DBG_MASK[n[IW-1:0]] || dbg);
    endfunction

    function automatic tok_t tok_at(input logic [2:0] idx, input logic [2:0] len,
                                    input logic ok, input logic [31:0] d);
        tok_t t;
        t = '{ctrl: 1'b0, val: 8'h00};
        if (idx == 3'h0) begin
            t = '{ctrl: 1'b1, val: ok ? `TOK_ACK : `TOK_NAK};
        end else if (idx == len - 3'h1) begin
            t = '{ctrl: 1'b1, val: `TOK_END};
        end else begin
            case (idx)
                3'h1: t.val = d[31:24];
                3'h2: t.val = d[23:16];
                3'h3: t.val = d[15:8];
                default: t.val = d[7:0];
            endcase
        end
        return t;
    endfunction

    // ==========================================================
    // State
    state_t state_r, state_nxt;
    logic [3:0] cnt_r;
    logic is_wr_r;
    logic [39:0] hdr_r;
    logic [31:0] data_r;
    logic ok_r;
    logic [2:0] idx_r;
    logic in_ready_r;
    tok_t out_tok_r;
    logic out_valid_r;
    logic [23:0] out_dest_r;
    logic proc_ack_r, proc_ok_r;
    logic [31:0] proc_rdata_r;
    logic [31:0] bank_r [NUM_REGS];

    // ==========================================================
    // Decode
    wire take = in_valid && in_ready_r;
    wire is_open = in_tok.ctrl && (in_tok.val == `TOK_WRITE || in_tok.val == `TOK_READ);
    wire is_end = in_tok.ctrl && in_tok.val == `TOK_END;
    wire [23:0] rid = hdr_r[39:16];
    wire [15:0] regn = hdr_r[15:0];
    wire msg_ok = allowed(regn, is_wr_r, dbg_mode);
    wire no_reply = is_wr_r && rid[7:0] == `NOREPLY_ID;
    wire [2:0] rsp_len = (ok_r && !is_wr_r) ? `RSP_LEN_READ : `RSP_LEN_SHORT;
    wire adv = !out_valid_r || out_ready;
    wire [15:0] proc_reg = proc_resid[23:8];
    wire proc_fmt = proc_resid[7:0] == `PS_RES_TYPE && proc_resid[31:24] == 8'h00;
    wire proc_go = proc_req && state_r != S_EXEC;
    wire proc_good = proc_fmt && allowed(proc_reg, proc_wr, dbg_mode);
    wire rx_state = state_nxt == S_IDLE || state_nxt == S_HDR ||
                    state_nxt == S_DATA || state_nxt == S_TAIL;

    // A stray control token in mid message drops the message silently,
    // since its return identifier cannot be trusted.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: begin
                if (take && is_open) state_nxt = S_HDR;
            end
            S_HDR: begin
                if (take && in_tok.ctrl) state_nxt = S_IDLE;
                else if (take && cnt_r == `HDR_LAST) state_nxt = is_wr_r ? S_DATA : S_TAIL;
            end
            S_DATA: begin
                if (take && in_tok.ctrl) state_nxt = S_IDLE;
                else if (take && cnt_r == `DATA_LAST) state_nxt = S_TAIL;
            end
            S_TAIL: begin
                if (take) state_nxt = is_end ? S_EXEC : S_IDLE;
            end
            S_EXEC: state_nxt = no_reply ? S_IDLE : S_REPLY;
            S_REPLY: begin
                if (adv && idx_r == rsp_len) state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    // ==========================================================
    // Message path
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_r <= S_IDLE;
            cnt_r <= 4'h0;
            in_ready_r <= 1'b0;
            is_wr_r <= 1'b0;
            hdr_r <= 40'h00_0000_0000;
            data_r <= 32'h0000_0000;
            ok_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            in_ready_r <= rx_state;
            cnt_r <= (state_nxt != state_r) ? 4'h0 : (take ? cnt_r + 4'h1 : cnt_r);
            if (state_r == S_IDLE && take) is_wr_r <= in_tok.val == `TOK_WRITE;
            if (state_r == S_HDR && take) hdr_r <= {hdr_r[31:0], in_tok.val};
            if (state_r == S_DATA && take) data_r <= {data_r[23:0], in_tok.val};
            if (state_r == S_EXEC) begin
                ok_r <= msg_ok;
                if (!is_wr_r) data_r <= msg_ok ? bank_r[regn[IW-1:0]] : 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Reply path
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            idx_r <= 3'h0;
            out_valid_r <= 1'b0;
            out_tok_r <= '{ctrl: 1'b0, val: 8'h00};
            out_dest_r <= 24'h00_0000;
        end else if (state_r == S_EXEC) begin
            idx_r <= 3'h0;
            out_dest_r <= rid;
        end else if (state_r == S_REPLY && adv) begin
            out_valid_r <= idx_r != rsp_len;
            if (idx_r != rsp_len) begin
                out_tok_r <= tok_at(idx_r, rsp_len, ok_r, data_r);
                idx_r <= idx_r + 3'h1;
            end
        end else if (out_ready) begin
            out_valid_r <= 1'b0;
        end
    end

    // ==========================================================
    // Register bank and processor port
    // The processor is held off only in the one cycle where a message
    // commits, so a single write port serves both.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            for (int i = 0; i < NUM_REGS; i++) bank_r[i] <= 32'h0000_0000;
            proc_ack_r <= 1'b0;
            proc_ok_r <= 1'b0;
            proc_rdata_r <= 32'h0000_0000;
        end else begin
            if (state_r == S_EXEC && is_wr_r && msg_ok) begin
                bank_r[regn[IW-1:0]] <= data_r;
            end else if (proc_go && proc_wr && proc_good) begin
                bank_r[proc_reg[IW-1:0]] <= proc_wdata;
            end
            proc_ack_r <= proc_go;
            proc_ok_r <= proc_go && proc_good;
            proc_rdata_r <= (proc_go && proc_good && !proc_wr) ?
                            bank_r[proc_reg[IW-1:0]] : 32'h0000_0000;
        end
    end

    assign in_ready = in_ready_r;
    assign out_tok = out_tok_r;
    assign out_valid = out_valid_r;
    assign out_dest = out_dest_r;
    assign proc_ack = proc_ack_r;
    assign proc_ok = proc_ok_r;
    assign proc_rdata = proc_rdata_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    wire proc_dbg_reg = proc_fmt && 32'(proc_reg) < NUM_REGS && DBG_MASK[proc_reg[IW-1:0]];

    reply_dest_a: assert property (state_r == S_EXEC && !no_reply |=> out_dest_r == $past(rid))
        else $error("reply not addressed to return id");
    no_reply_a: assert property (state_r == S_EXEC && no_reply |-> ##1 !out_valid_r [*3])
        else $error("reply sent for suppressed write");
    msb_first_a: assert property (state_r == S_DATA && take
        |=> data_r == {$past(data_r[23:0]), $past(in_tok.val)})
        else $error("data not assembled most significant byte first");
    write_ack_a: assert property (state_r == S_EXEC && is_wr_r && !no_reply
        |-> ##2 out_valid_r && out_tok_r.ctrl && out_tok_r.val == (ok_r ? `TOK_ACK : `TOK_NAK))
        else $error("wrong write reply token");
    read_byte_a: assert property (state_r == S_REPLY && !is_wr_r && ok_r && idx_r == 3'h1
        && adv |=> !out_tok_r.ctrl && out_tok_r.val == data_r[31:24])
        else $error("read reply does not start with top byte");
    read_nak_a: assert property (state_r == S_REPLY && !ok_r && idx_r == 3'h1 && adv
        |=> out_tok_r.ctrl && out_tok_r.val == `TOK_END)
        else $error("failed read reply carries data");
    ps_decode_a: assert property (proc_go && proc_resid[7:0] != `PS_RES_TYPE
        |=> proc_ack_r && !proc_ok_r)
        else $error("bad resource type accepted");
    ps_word_a: assert property (proc_go && proc_wr && proc_good
        |=> bank_r[$past(proc_reg[IW-1:0])] == $past(proc_wdata))
        else $error("status write did not store whole word");
    debug_gate_a: assert property (proc_go && !dbg_mode && proc_dbg_reg |=> !proc_ok_r)
        else $error("debug register reached outside debug mode");
    unmapped_nak_a: assert property (state_r == S_EXEC && 32'(regn) >= NUM_REGS |=> !ok_r)
        else $error("unmapped register not refused");

    write_reply_c: cover property (state_r == S_EXEC && is_wr_r && !no_reply ##2 out_valid_r);
    read_ok_c: cover property (state_r == S_EXEC && !is_wr_r && msg_ok);
    silent_write_c: cover property (state_r == S_EXEC && no_reply);
    proc_read_c: cover property (proc_go && !proc_wr && proc_good);

endmodule // config_register_message_agent

`default_nettype wire

// ==== bench/remote_end_model.sv ====
`timescale 1ns/10ps
`default_nettype none

module remote_end_model import cfg_agent_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Reply stream
    input wire tok_t out_tok,
    input wire logic out_valid,
    input wire logic [23:0] out_dest,
    output logic out_ready,
    // Bench side
    input wire logic stall,
    output logic seen,
    output logic [32:0] seen_word
);
    // ==========
    // Reply sink
    // A stalling sink drops ready at random, so the agent must hold each token.
    always @(posedge clock) begin
        out_ready <= rst_b && (!stall || $urandom_range(1));
        seen <= rst_b && out_valid && out_ready;
        seen_word <= {out_dest, out_tok};
    end
endmodule // remote_end_model

`default_nettype wire

// ==== bench/test_config_register_message_agent.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "cfg_agent_params.svh"

module test_config_register_message_agent import cfg_agent_pkg::*;;
    logic clock = 1'b0, rst_b = 1'b0, in_valid = 1'b0, dbg_mode = 1'b0, stall = 1'b0;
    logic proc_req = 1'b0, proc_wr = 1'b0, in_ready, out_valid, out_ready;
    logic proc_ack, proc_ok, seen;
    tok_t in_tok = '0, out_tok;
    logic [31:0] proc_resid = 0, proc_wdata = 0, proc_rdata, d;
    logic [23:0] out_dest, rid;
    logic [32:0] seen_word, rq[$];
    logic [15:0] rn;
    int fails = 0, n_tests = 0;

    // Every request below is aimed at the node's c300 configuration endpoint.
    config_register_message_agent config_register_message_agent_i (
        .clock(clock), .rst_b(rst_b), .in_tok(in_tok), .in_valid(in_valid),
        .in_ready(in_ready), .out_tok(out_tok), .out_valid(out_valid),
        .out_dest(out_dest), .out_ready(out_ready), .dbg_mode(dbg_mode),
        .proc_req(proc_req), .proc_wr(proc_wr), .proc_resid(proc_resid),
        .proc_wdata(proc_wdata), .proc_ack(proc_ack), .proc_ok(proc_ok),
        .proc_rdata(proc_rdata));
    remote_end_model remote_end_model_i (
        .clock(clock), .rst_b(rst_b), .out_tok(out_tok), .out_valid(out_valid),
        .out_dest(out_dest), .out_ready(out_ready), .stall(stall), .seen(seen),
        .seen_word(seen_word));

    always #50 clock = ~clock;
    always @(posedge clock) if (seen === 1'b1) rq.push_back(seen_word);

    // ==========
    // Shared tasks
    task chk(input logic [32:0] g, input logic [32:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, g, e);
        end
    endtask

    task test_done;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic send(input logic c, input logic [7:0] v);
        int k = 0;
        in_tok <= '{c, v};
        in_valid <= 1'b1;
        @(negedge clock);
        while (in_ready !== 1'b1 && k < 50) begin
            k++;
            @(negedge clock);
        end
        if (in_ready !== 1'b1) begin
            fails++;
            test_done();
        end
        @(posedge clock);
    endtask

    task automatic msg(input logic wr, input logic [23:0] r, input logic [15:0] n,
                       input logic [31:0] v);
        send(1'b1, wr ? `TOK_WRITE : `TOK_READ);
        for (int i = 16; i >= 0; i -= 8) send(1'b0, r[i+:8]);
        for (int i = 8; i >= 0; i -= 8) send(1'b0, n[i+:8]);
        if (wr) for (int i = 24; i >= 0; i -= 8) send(1'b0, v[i+:8]);
        send(1'b1, `TOK_END);
        in_valid <= 1'b0;
        in_tok <= ~in_tok;
    endtask

    // Builds the expected reply and waits, bounded, for the sink to collect it.
    task automatic rsp(input logic ok, input logic rd, input logic [31:0] v,
                       input logic [23:0] r);
        logic [8:0] e[$];
        int k = 0;
        e = '{{1'b1, ok ? `TOK_ACK : `TOK_NAK}};
        if (ok && rd) for (int i = 24; i >= 0; i -= 8) e.push_back({1'b0, v[i+:8]});
        e.push_back({1'b1, `TOK_END});
        while (rq.size() < e.size() && k < 300) begin
            k++;
            @(posedge clock);
        end
        if (rq.size() < e.size()) begin
            fails++;
            test_done();
        end
        repeat (4) @(posedge clock);
        chk(rq.size(), e.size());
        foreach (e[i]) chk(rq[i], {r, e[i]});
        rq = '{};
    endtask

    task automatic ps(input logic wr, input logic [7:0] ty, input logic [7:0] n,
                      input logic [31:0] v, input logic ok, input logic [31:0] rv);
        proc_req <= 1'b1;
        proc_wr <= wr;
        proc_resid <= {16'h0000, n, ty};
        proc_wdata <= v;
        @(posedge clock);
        proc_req <= 1'b0;
        @(negedge clock);
        chk(proc_ack, 1'b1);
        chk(proc_ok, ok);
        chk(proc_rdata, rv);
        @(posedge clock);
    endtask

    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'hefa7_627c));
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        msg(1'b0, 24'h12_3456, 16'h0003, 32'h0);
        rsp(1'b1, 1'b1, 32'h0, 24'h12_3456);
        $display("reset test done");
        stall <= 1'b1;
        repeat (6) begin
            rn = 16'h0001 + 16'($urandom % 7);
            rid = 24'($urandom);
            if (rid[7:0] == 8'hff) rid[7:0] = 8'h00;
            d = $urandom;
            msg(1'b1, rid, rn, d);
            rsp(1'b1, 1'b0, d, rid);
            msg(1'b0, rid, rn, d);
            rsp(1'b1, 1'b1, d, rid);
        end
        $display("random test done");
        msg(1'b1, rid, 16'h0000, d);
        rsp(1'b0, 1'b0, d, rid);
        msg(1'b0, rid, 16'h0014, d);
        rsp(1'b0, 1'b1, d, rid);
        msg(1'b0, rid, 16'h0000, d);
        rsp(1'b1, 1'b1, 32'h0, rid);
        $display("failure test done");
        msg(1'b1, 24'h44_55ff, 16'h0002, 32'h5a5a_c3c3);
        send(1'b1, `TOK_READ);
        send(1'b0, 8'h12);
        send(1'b1, `TOK_END);
        in_valid <= 1'b0;
        repeat (20) @(posedge clock);
        chk(rq.size(), 0);
        msg(1'b0, rid, 16'h0002, d);
        rsp(1'b1, 1'b1, 32'h5a5a_c3c3, rid);
        $display("silent write test done");
        ps(1'b1, 8'h0b, 8'h04, d, 1'b1, 32'h0);
        ps(1'b0, 8'h0b, 8'h04, d, 1'b1, d);
        ps(1'b0, 8'h0b, 8'h02, d, 1'b1, 32'h5a5a_c3c3);
        ps(1'b0, 8'h0c, 8'h02, d, 1'b0, 32'h0);
        ps(1'b1, 8'h0b, 8'h00, d, 1'b0, 32'h0);
        ps(1'b1, 8'h0b, 8'h09, d, 1'b0, 32'h0);
        dbg_mode <= 1'b1;
        ps(1'b1, 8'h0b, 8'h09, ~d, 1'b1, 32'h0);
        ps(1'b0, 8'h0b, 8'h09, d, 1'b1, ~d);
        dbg_mode <= 1'b0;
        ps(1'b0, 8'h0b, 8'h09, d, 1'b0, 32'h0);
        $display("processor test done");
        rst_b <= 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        ps(1'b0, 8'h0b, 8'h04, d, 1'b1, 32'h0);
        msg(1'b0, rid, 16'h0002, d);
        rsp(1'b1, 1'b1, 32'h0, rid);
        $display("second reset test done");
        test_done();
    end
endmodule // test_config_register_message_agent

`default_nettype wire
